// [logic/epa_pkg.sv]
// epa_pkg: constants and carrier types for the enclave page-accept checker
// assumes one core clock; every user of it writes epa_pkg::name
`default_nettype none
package epa_pkg;
  // leaf index that selects page accept in the accumulator
  localparam logic [31:0] LEAF_ACCEPT = 32'h0000_0005;
  // page type codes of the map entry and the security info flags
  localparam logic [7:0] PT_REGULAR   = 8'h01;
  localparam logic [7:0] PT_THREAD    = 8'h02;
  localparam logic [7:0] PT_TRIMMED   = 8'h04;
  localparam logic [7:0] PT_SHADOW_F  = 8'h05;
  localparam logic [7:0] PT_SHADOW_R  = 8'h06;
  // security info flag word layout (low 64 bits of the 512-bit copy)
  localparam int SI_R      = 0;
  localparam int SI_W      = 1;
  localparam int SI_X      = 2;
  localparam int SI_PEND   = 3;
  localparam int SI_MOD    = 4;
  localparam int SI_RESTRICT = 5;
  localparam int SI_PT_LO  = 8;
  localparam int SI_FLAG_W = 64;
  localparam logic [63:0] SI_FLAGS_RSVD = 64'hffff_ffff_ffff_00c0;
  // alignment masks and segment limit pattern
  localparam logic [63:0] ALIGN_SI   = 64'h0000_0000_0000_003f;
  localparam logic [63:0] ALIGN_PAGE = 64'h0000_0000_0000_0fff;
  localparam int          PAGE_SH    = 12;
  localparam logic [11:0] LIMIT_LOW  = 12'hfff;
  // register offsets and control bits
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_STATUS = 4'h4;
  localparam logic [3:0]  REG_RAX    = 4'h8;
  localparam int          CTRL_FEAT2 = 0;
  localparam int          CTRL_SSCAP = 1;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0001;

  typedef enum logic [2:0] {
    RES_NONE = 3'h0, RES_OK = 3'h1, RES_GP = 3'h2, RES_PF = 3'h3, RES_ERR = 3'h4
  } epa_res_e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001, ST_PRE = 5'b00010, ST_LOCK = 5'b00100,
    ST_POST = 5'b01000, ST_HOLD = 5'b10000
  } epa_st_e;

  // one page cache map entry as presented by the map lookup
  typedef struct packed {
    logic        valid;
    logic        r;
    logic        w;
    logic        x;
    logic        pending;
    logic        modified;
    logic        restrict_f;
    logic        blocked;
    logic [7:0]  pt;
    logic [15:0] owner;
    logic [51:0] lin_page;
  } epa_map_s;

  // thread control structure fields of the destination page
  typedef struct packed {
    logic        rsvd_nz;
    logic        debug_opt_in;
    logic [31:0] save_idx;
    logic [31:0] save_cnt;
    logic [63:0] exit_ptr;
    logic [63:0] state;
    logic [63:0] prev_ssp;
    logic [31:0] fs_limit;
    logic [31:0] gs_limit;
  } epa_thr_s;

  // completion record of one accept
  typedef struct packed {
    logic        done;
    epa_res_e    outcome;
    logic [63:0] addr;
    logic [63:0] rax;
    logic        zf;
    logic [4:0]  arith;
    logic        flags_wr;
    logic        map_wr;
  } epa_out_s;
endpackage
`default_nettype wire

// [logic/epa_accept.sv]
// epa_accept: execution and check logic of the user-level page accept leaf
// assumes all inputs come from core logic on clk; map entries and structure
// fields are presented live by the lookup logic for the captured addresses
// Operation
// RL1: leaf 05H selects accept, second set only
// RL2: reject accept outside an enclave
// RL3: software loads info address and page address
// RL4: info address not 64-byte aligned faults
// RL5: info address range, memory, entry checks
// RL6: copy 512-bit info, reserved non-zero faults
// RL7: page alignment, range, memory checks
// RL8: legal flag combinations without shadow capability
// RL9: shadow page types legal with capability
// RL10: destination entry validity, owner, type checks
// RL11: page in use faults, then recheck
// RL12: shared access against base restrictions
// RL13: exclusive against accept-family, others concurrent
// RL14: attribute mismatch sets zero flag, code
// RL15: tracking incomplete returns not-tracked code
// RL16: thread page reserved area must be zero
// RL17: thread structure fields must be initialised
// RL18: narrow mode needs segment limits low FFFH
// RL19: success clears flags, zero flag, return
// RL20: arithmetic flags cleared on completion
// RL21: checks in order, first failure reported
`timescale 1ns/10ps
`default_nettype none
module epa_accept #(
  parameter logic [63:0] ATTR_CODE  = 64'h0000_0000_0000_0013, // mismatch return
  parameter logic [63:0] TRACK_CODE = 64'h0000_0000_0000_000b  // not-tracked return
) (
  input  wire logic              clk,           // core clock, 50 MHz
  input  wire logic              reset_n,       // synchronous reset, low active
  input  wire logic              clk_en,        // freezes all state while low
  input  wire logic [3:0]        reg_addr,      // register byte address
  input  wire logic [31:0]       reg_wdata,     // register write data
  input  wire logic              reg_wr,        // write strobe
  input  wire logic              reg_rd,        // read strobe
  output logic      [31:0]       reg_rdata,     // read data, cycle after strobe
  input  wire logic              start,         // instruction issue pulse
  input  wire logic [31:0]       leaf_idx,      // accumulator leaf index
  input  wire logic              in_enclave,    // executing inside an enclave
  input  wire logic [63:0]       rbx,           // security info address
  input  wire logic [63:0]       rcx,           // destination page address
  input  wire logic [63:0]       elr_base,      // enclave linear range base
  input  wire logic [63:0]       elr_end,       // enclave linear range end, excl
  input  wire logic [511:0]      si_data,       // 64-byte info contents
  input  wire logic              si_in_prot,    // info address in protected memory
  input  wire logic              dst_in_prot,   // page address in protected memory
  input  wire epa_pkg::epa_map_s si_map,        // map entry of the info page
  input  wire epa_pkg::epa_map_s dst_map,       // map entry of the destination
  input  wire logic [15:0]       active_owner,  // running enclave control id
  input  wire logic              dst_in_use,    // page held by another operation
  input  wire logic              base_conflict, // shared access refused
  input  wire logic              excl_conflict, // accept-family op holds page
  input  wire logic              track_done,    // exit tracking complete
  input  wire logic              wide_mode,     // enclave in 64-bit mode
  input  wire epa_pkg::epa_thr_s thr_fields,    // destination thread fields
  output logic                   lock_req,      // asks for the page lock
  output logic                   lock_hold,     // page held exclusively
  output epa_pkg::epa_out_s      res            // completion record
);

  // whole module state
  typedef struct packed {
    epa_pkg::epa_st_e  st;
    logic [63:0]       rbx;
    logic [63:0]       rcx;
    logic [511:0]      si;
    logic [31:0]       ctrl;
    logic              hold;
    logic [31:0]       rdata;
    epa_pkg::epa_out_s o;
  } epa_state_s;

  epa_state_s s_q;
  epa_state_s s_d;

  // ends the instruction; faults leave flags alone, returns rewrite them
  function automatic epa_state_s fin(epa_state_s x, epa_pkg::epa_res_e r,
                                     logic [63:0] a, logic [63:0] code);
    epa_state_s y;
    y            = x;
    y.st         = epa_pkg::ST_IDLE;
    y.hold       = 1'b0;
    y.o.done     = 1'b1;
    y.o.outcome  = r;
    y.o.addr     = a;
    if (r == epa_pkg::RES_OK || r == epa_pkg::RES_ERR) begin
      y.o.rax      = code;
      y.o.zf       = (r == epa_pkg::RES_ERR);
      y.o.arith    = 5'h00; // [RL20]
      y.o.flags_wr = 1'b1;  // [RL20]
    end
    y.o.map_wr   = (r == epa_pkg::RES_OK); // [RL19]
    return y;
  endfunction

  // decoded request fields
  logic [7:0] pt;
  logic       pend;
  logic       modf;
  logic       prf;
  logic       ss_cap;
  logic       si_rsvd;
  logic       combo_ok;
  logic       si_ent_bad;
  logic       dst_ent_bad;
  logic       dst_pt_ok;
  logic       mismatch;
  logic       thr_bad;
  logic       limit_bad;

  assign pt      = s_q.si[epa_pkg::SI_PT_LO +: 8];
  assign pend    = s_q.si[epa_pkg::SI_PEND];
  assign modf    = s_q.si[epa_pkg::SI_MOD];
  assign prf     = s_q.si[epa_pkg::SI_RESTRICT];
  assign ss_cap  = s_q.ctrl[epa_pkg::CTRL_SSCAP];
  // reserved flag bits and the upper 56 bytes of the copy
  assign si_rsvd = ((s_q.si[epa_pkg::SI_FLAG_W-1:0] & epa_pkg::SI_FLAGS_RSVD) != 64'h0) ||
                   (s_q.si[511:epa_pkg::SI_FLAG_W] != 448'h0); // [RL6]

  // legal type/pending/modified/restrict combinations
  always_comb begin
    combo_ok = (pt == epa_pkg::PT_REGULAR && (prf || pend) && !modf) || // [RL8]
               ((pt == epa_pkg::PT_THREAD || pt == epa_pkg::PT_TRIMMED) &&
                !prf && !pend && modf);
    if (ss_cap) begin
      combo_ok = combo_ok ||
                 ((pt == epa_pkg::PT_SHADOW_F || pt == epa_pkg::PT_SHADOW_R) &&
                  pend && !modf && !prf); // [RL9]
    end
  end

  // map entry checks for the info page and the destination
  assign si_ent_bad = !si_map.valid || !si_map.r || si_map.pending || si_map.modified ||
                      si_map.blocked || si_map.pt != epa_pkg::PT_REGULAR ||
                      si_map.owner != active_owner ||
                      si_map.lin_page != s_q.rbx[63:epa_pkg::PAGE_SH]; // [RL5]
  assign dst_pt_ok  = dst_map.pt == epa_pkg::PT_REGULAR || dst_map.pt == epa_pkg::PT_THREAD ||
                      dst_map.pt == epa_pkg::PT_TRIMMED || dst_map.pt == epa_pkg::PT_SHADOW_F ||
                      dst_map.pt == epa_pkg::PT_SHADOW_R;
  assign dst_ent_bad = !dst_map.valid || dst_map.blocked || !dst_pt_ok ||
                       dst_map.owner != active_owner; // [RL10]
  assign mismatch   = dst_map.lin_page != s_q.rcx[63:epa_pkg::PAGE_SH] ||
                      dst_map.pending != pend || dst_map.modified != modf ||
                      dst_map.r != s_q.si[epa_pkg::SI_R] ||
                      dst_map.w != s_q.si[epa_pkg::SI_W] ||
                      dst_map.x != s_q.si[epa_pkg::SI_X]; // [RL14]
  assign thr_bad    = thr_fields.debug_opt_in || thr_fields.save_idx >= thr_fields.save_cnt ||
                      thr_fields.exit_ptr != 64'h0 || thr_fields.state != 64'h0 ||
                      (ss_cap && thr_fields.prev_ssp != 64'h0); // [RL17]
  assign limit_bad  = !wide_mode && (thr_fields.fs_limit[11:0] != epa_pkg::LIMIT_LOW ||
                                     thr_fields.gs_limit[11:0] != epa_pkg::LIMIT_LOW); // [RL18]

  // next state: one check stage per state, first failure ends the run
  always_comb begin
    s_d            = s_q;
    s_d.o.done     = 1'b0;
    s_d.o.flags_wr = 1'b0;
    s_d.o.map_wr   = 1'b0;
    s_d.rdata      = 32'h0;
    case (s_q.st)
      epa_pkg::ST_IDLE: begin
        if (start && leaf_idx == epa_pkg::LEAF_ACCEPT &&
            s_q.ctrl[epa_pkg::CTRL_FEAT2]) begin // [RL1]
          s_d.rbx = rbx; // [RL3]
          s_d.rcx = rcx;
          s_d.si  = si_data; // [RL6]
          if (!in_enclave) begin
            s_d = fin(s_q, epa_pkg::RES_GP, 64'h0, 64'h0); // [RL2]
          end else begin
            s_d.st = epa_pkg::ST_PRE;
          end
        end
      end
      epa_pkg::ST_PRE: begin
        // ordered operand checks [RL21]
        if ((s_q.rbx & epa_pkg::ALIGN_SI) != 64'h0) begin
          s_d = fin(s_q, epa_pkg::RES_GP, 64'h0, 64'h0); // [RL4]
        end else if (s_q.rbx < elr_base || s_q.rbx >= elr_end) begin
          s_d = fin(s_q, epa_pkg::RES_GP, 64'h0, 64'h0); // [RL5]
        end else if (!si_in_prot || si_ent_bad) begin
          s_d = fin(s_q, epa_pkg::RES_PF, s_q.rbx, 64'h0); // [RL5]
        end else if (si_rsvd) begin
          s_d = fin(s_q, epa_pkg::RES_GP, 64'h0, 64'h0); // [RL6]
        end else if ((s_q.rcx & epa_pkg::ALIGN_PAGE) != 64'h0 ||
                     s_q.rcx < elr_base || s_q.rcx >= elr_end) begin
          s_d = fin(s_q, epa_pkg::RES_GP, 64'h0, 64'h0); // [RL7]
        end else if (!dst_in_prot) begin
          s_d = fin(s_q, epa_pkg::RES_PF, s_q.rcx, 64'h0); // [RL7]
        end else if (!combo_ok) begin
          s_d = fin(s_q, epa_pkg::RES_GP, 64'h0, 64'h0); // [RL8] [RL9]
        end else if (dst_ent_bad) begin
          s_d = fin(s_q, epa_pkg::RES_PF, s_q.rcx, 64'h0); // [RL10]
        end else begin
          s_d.st = epa_pkg::ST_LOCK;
        end
      end
      epa_pkg::ST_LOCK: begin
        // lock_req is high here; the info operand takes no lock at all
        if (dst_in_use) begin
          s_d = fin(s_q, epa_pkg::RES_GP, 64'h0, 64'h0); // [RL11]
        end else if (base_conflict) begin
          s_d = fin(s_q, epa_pkg::RES_GP, 64'h0, 64'h0); // [RL12]
        end else if (excl_conflict) begin
          s_d = fin(s_q, epa_pkg::RES_GP, 64'h0, 64'h0); // [RL13]
        end else begin
          s_d.hold = 1'b1; // [RL13]
          s_d.st   = epa_pkg::ST_POST;
        end
      end
      epa_pkg::ST_POST: begin
        // entry may have changed before the lock was taken, so look again
        if (!dst_map.valid || dst_map.owner != active_owner) begin
          s_d = fin(s_q, epa_pkg::RES_PF, s_q.rcx, 64'h0); // [RL11]
        end else if (mismatch) begin
          s_d = fin(s_q, epa_pkg::RES_ERR, s_q.rcx, ATTR_CODE); // [RL14]
        end else if (!track_done) begin
          s_d = fin(s_q, epa_pkg::RES_ERR, s_q.rcx, TRACK_CODE); // [RL15]
        end else if (pt == epa_pkg::PT_THREAD) begin
          s_d.st = epa_pkg::ST_HOLD;
        end else begin
          s_d = fin(s_q, epa_pkg::RES_OK, s_q.rcx, 64'h0); // [RL19]
        end
      end
      epa_pkg::ST_HOLD: begin
        // thread control page field checks
        if (thr_fields.rsvd_nz) begin
          s_d = fin(s_q, epa_pkg::RES_GP, 64'h0, 64'h0); // [RL16]
        end else if (thr_bad || limit_bad) begin
          s_d = fin(s_q, epa_pkg::RES_GP, 64'h0, 64'h0); // [RL17] [RL18]
        end else begin
          s_d = fin(s_q, epa_pkg::RES_OK, s_q.rcx, 64'h0); // [RL19]
        end
      end
      default: begin
        s_d.st   = epa_pkg::ST_IDLE;
        s_d.hold = 1'b0;
      end
    endcase
    // register port; the slave never stalls
    if (reg_wr && reg_addr == epa_pkg::REG_CTRL) begin
      s_d.ctrl = reg_wdata;
    end
    if (reg_rd) begin
      case (reg_addr)
        epa_pkg::REG_CTRL:   s_d.rdata = s_q.ctrl;
        epa_pkg::REG_STATUS: s_d.rdata = {27'h0, s_q.st != epa_pkg::ST_IDLE, s_q.o.outcome,
                                          s_q.o.zf};
        epa_pkg::REG_RAX:    s_d.rdata = s_q.o.rax[31:0];
        default:             s_d.rdata = 32'h0;
      endcase
    end
  end

  // state register; clock enable freezes everything
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q      <= '0;
      s_q.st   <= epa_pkg::ST_IDLE;
      s_q.ctrl <= epa_pkg::CTRL_RST;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // outputs
  assign reg_rdata = s_q.rdata;
  assign res       = s_q.o;
  assign lock_hold = s_q.hold;
  assign lock_req  = (s_q.st == epa_pkg::ST_LOCK); // [RL12]

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_leaf_select: assert property ( // [RL1]
    (clk_en && s_q.st == epa_pkg::ST_IDLE && start && leaf_idx != epa_pkg::LEAF_ACCEPT)
    |=> (s_q.st == epa_pkg::ST_IDLE && !s_q.o.done))
    else $error("wrong leaf started an accept");

  chk_outside_enclave: assert property ( // [RL2]
    (clk_en && s_q.st == epa_pkg::ST_IDLE && start && leaf_idx == epa_pkg::LEAF_ACCEPT &&
     s_q.ctrl[epa_pkg::CTRL_FEAT2] && !in_enclave)
    |=> (res.done && res.outcome == epa_pkg::RES_GP))
    else $error("accept outside enclave not refused");

  chk_info_align: assert property ( // [RL4]
    (clk_en && s_q.st == epa_pkg::ST_PRE && (s_q.rbx & epa_pkg::ALIGN_SI) != 64'h0)
    |=> (res.done && res.outcome == epa_pkg::RES_GP))
    else $error("misaligned info address not faulted");

  chk_ok_aligned: assert property ( // [RL7]
    (res.done && res.outcome == epa_pkg::RES_OK)
    |-> ((s_q.rcx & epa_pkg::ALIGN_PAGE) == 64'h0 && s_q.rcx >= elr_base))
    else $error("accepted a misaligned page");

  chk_in_use_fault: assert property ( // [RL11]
    (clk_en && s_q.st == epa_pkg::ST_LOCK && dst_in_use)
    |=> (res.done && res.outcome == epa_pkg::RES_GP && !lock_hold))
    else $error("page in use not faulted");

  chk_excl_hold: assert property ( // [RL13]
    (s_q.st == epa_pkg::ST_POST || s_q.st == epa_pkg::ST_HOLD) |-> lock_hold)
    else $error("page not held while checked");

  chk_success_write: assert property ( // [RL19]
    res.map_wr |-> (res.outcome == epa_pkg::RES_OK && !res.zf && res.rax == 64'h0 &&
                    ($past(lock_hold) || !$past(clk_en))))
    else $error("map update without clean success");

  chk_err_no_write: assert property ( // [RL14]
    (res.done && res.outcome == epa_pkg::RES_ERR) |-> (res.zf && !res.map_wr &&
     (res.rax == ATTR_CODE || res.rax == TRACK_CODE)))
    else $error("error return malformed");

  chk_flags_clear: assert property ( // [RL20]
    res.flags_wr |-> (res.done && res.arith == 5'h00 && res.outcome != epa_pkg::RES_GP))
    else $error("arithmetic flags not cleared");

  chk_fault_addr: assert property ( // [RL5]
    (res.done && res.outcome == epa_pkg::RES_PF) |-> (res.addr == s_q.rbx ||
                                                      res.addr == s_q.rcx))
    else $error("page fault address wrong");

  // a mismatch after a good recheck must end as an error return, page untouched
  chk_mismatch_code: assert property ( // [RL14]
    (clk_en && s_q.st == epa_pkg::ST_POST && dst_map.valid &&
     dst_map.owner == active_owner && mismatch)
    |=> (res.done && res.zf && res.rax == ATTR_CODE && !res.map_wr))
    else $error("attribute mismatch not returned");

  chk_not_tracked: assert property ( // [RL15]
    (clk_en && s_q.st == epa_pkg::ST_POST && dst_map.valid &&
     dst_map.owner == active_owner && !mismatch && !track_done)
    |=> (res.done && res.zf && res.rax == TRACK_CODE && !res.map_wr))
    else $error("incomplete tracking not returned");

  chk_lock_taken: assert property ( // [RL12]
    (clk_en && lock_req && !dst_in_use && !base_conflict && !excl_conflict) |=> lock_hold)
    else $error("free page not taken");

  cov_success: cover property (res.done && res.outcome == epa_pkg::RES_OK);
  cov_mismatch: cover property (res.done && res.rax == ATTR_CODE && res.zf);
  cov_not_tracked: cover property (res.done && res.rax == TRACK_CODE && res.zf);
  cov_thread_ok: cover property (s_q.st == epa_pkg::ST_HOLD ##1 res.map_wr);
  cov_shadow_ok: cover property (res.map_wr && pt == epa_pkg::PT_SHADOW_R);
endmodule
`default_nettype wire

// [testbench/epa_accept_tb.sv]
// epa_accept_tb: self-checking bench for the page accept execution logic
// assumes logic/epa_pkg.sv and logic/epa_accept.sv are compiled first
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) chk_val(64'(g), 64'(e));
module epa_accept_tb;
  localparam logic [63:0] ELB  = 64'h0000_0000_1000_0000; // range base
  localparam logic [63:0] ELE  = 64'h0000_0000_1010_0000; // range end, 256 pages
  localparam logic [63:0] ATTR = 64'h0000_0000_0000_0013; // mismatch return
  localparam logic [63:0] TRK  = 64'h0000_0000_0000_000b; // not-tracked return
  localparam logic [2:0]  OK   = epa_pkg::RES_OK;
  localparam logic [2:0]  GP   = epa_pkg::RES_GP;
  localparam logic [2:0]  PF   = epa_pkg::RES_PF;
  localparam logic [2:0]  ER   = epa_pkg::RES_ERR;

  logic                clk = 1'b0;
  logic                reset_n, clk_en, reg_wr, reg_rd, start, in_enclave;
  logic                si_in_prot, dst_in_prot, dst_in_use, base_conflict;
  logic                excl_conflict, track_done, wide_mode, lock_req, lock_hold;
  logic [3:0]          reg_addr;
  logic [31:0]         reg_wdata, reg_rdata, leaf_idx, seed, lf;
  logic [7:0]          fl; // level inputs of one case, driven once at its end
  logic [63:0]         rbx, rcx, elr_base, elr_end, rb, rc, sf, ea, er;
  logic [511:0]        si_data;
  logic [15:0]         active_owner;
  logic                hb;
  logic [2:0]          eo;
  int                  lat, bad_count, comparisons;
  epa_pkg::epa_map_s   si_map, dst_map, smap, dmap;
  epa_pkg::epa_thr_s   thr_fields, tc;
  epa_pkg::epa_out_s   res;

  epa_accept #(.ATTR_CODE(ATTR), .TRACK_CODE(TRK)) epa_accept_inst (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .start(start), .leaf_idx(leaf_idx), .in_enclave(in_enclave), .rbx(rbx), .rcx(rcx),
    .elr_base(elr_base), .elr_end(elr_end), .si_data(si_data), .si_in_prot(si_in_prot),
    .dst_in_prot(dst_in_prot), .si_map(si_map), .dst_map(dst_map),
    .active_owner(active_owner), .dst_in_use(dst_in_use), .base_conflict(base_conflict),
    .excl_conflict(excl_conflict), .track_done(track_done), .wide_mode(wide_mode),
    .thr_fields(thr_fields), .lock_req(lock_req), .lock_hold(lock_hold), .res(res));

  // free-running core clock, 20 ns period
  always #10 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // strobes are one cycle; read data is sampled in the cycle after the strobe
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic ex(input logic [2:0] o, input int l, input logic [63:0] a, r);
    eo = o;
    lat = l;
    ea = a;
    er = r;
  endtask

  // turn the request into a thread-control page accept
  task automatic thr;
    sf[epa_pkg::SI_PEND] = 1'b0;
    sf[epa_pkg::SI_MOD] = 1'b1;
    sf[15:8] = epa_pkg::PT_THREAD;
    dmap.pending = 1'b0;
    dmap.modified = 1'b1;
    dmap.pt = epa_pkg::PT_THREAD;
    ex(OK, 5, rc, 0);
  endtask

  // legal regular accept with random pages and rights, then one twist per case
  task automatic set_case(input int k);
    seed = xs(seed);
    rb = ELB + {44'h0, seed[7:0], 12'h0} + {52'h0, seed[13:8], 6'h0};
    rc = ELB + {44'h0, seed[23:16], 12'h0};
    smap = '0;
    smap.valid = 1'b1;
    smap.r = 1'b1;
    smap.pt = epa_pkg::PT_REGULAR;
    smap.owner = {seed[31:24], 8'h5a};
    smap.lin_page = rb[63:12];
    dmap = smap;
    dmap.pending = 1'b1;
    {dmap.x, dmap.w, dmap.r} = seed[26:24];
    dmap.lin_page = rc[63:12];
    sf = '0;
    sf[2:0] = seed[26:24];
    sf[epa_pkg::SI_PEND] = 1'b1;
    sf[15:8] = epa_pkg::PT_REGULAR;
    hb = 1'b0;
    tc = '0;
    tc.save_cnt = 32'h1;
    tc.fs_limit = 32'h0000_0fff;
    tc.gs_limit = 32'h0000_0fff;
    lf = epa_pkg::LEAF_ACCEPT;
    // in_enclave, si_in_prot, dst_in_prot, track_done, wide_mode, in_use, base, excl
    fl = 8'hf8;
    active_owner <= {seed[31:24], 8'h5a};
    ex(OK, 4, rc, 0);
    case (k)
      1: begin fl[7] = 1'b0; ex(GP, 1, 0, 0); end
      2: begin rb[3] = 1'b1; fl[5] = 1'b0; ex(GP, 2, 0, 0); end
      3: begin rb = ELE + 64'h40; smap.lin_page = rb[63:12]; ex(GP, 2, 0, 0); end
      4: begin fl[6] = 1'b0; ex(PF, 2, rb, 0); end
      5: begin smap.pending = 1'b1; ex(PF, 2, rb, 0); end
      6: begin smap.owner[0] = ~smap.owner[0]; ex(PF, 2, rb, 0); end
      7: begin sf[6] = 1'b1; ex(GP, 2, 0, 0); end
      8: begin hb = 1'b1; ex(GP, 2, 0, 0); end
      9: begin rc[11] = 1'b1; ex(GP, 2, 0, 0); end
      10: begin rc = ELE; ex(GP, 2, 0, 0); end
      11: begin fl[5] = 1'b0; ex(PF, 2, rc, 0); end
      12: begin sf[epa_pkg::SI_PEND] = 1'b0; ex(GP, 2, 0, 0); end
      13: begin
        sf[epa_pkg::SI_PEND] = 1'b0;
        sf[epa_pkg::SI_RESTRICT] = 1'b1;
        dmap.pending = 1'b0;
      end
      14: begin sf[15:8] = epa_pkg::PT_SHADOW_F; ex(GP, 2, 0, 0); end
      15: begin dmap.blocked = 1'b1; ex(PF, 2, rc, 0); end
      16: begin dmap.pt = 8'h03; ex(PF, 2, rc, 0); end
      17: begin dmap.owner[0] = ~dmap.owner[0]; ex(PF, 2, rc, 0); end
      18: begin fl[2] = 1'b1; ex(GP, 3, 0, 0); end
      19: begin fl[1] = 1'b1; ex(GP, 3, 0, 0); end
      20: begin fl[0] = 1'b1; ex(GP, 3, 0, 0); end
      21: begin dmap.w = ~dmap.w; ex(ER, 4, rc, ATTR); end
      22: begin dmap.lin_page[0] = ~dmap.lin_page[0]; ex(ER, 4, rc, ATTR); end
      23: begin fl[4] = 1'b0; ex(ER, 4, rc, TRK); end
      24: begin thr; tc.prev_ssp = 64'h1; end
      25: begin thr; tc.rsvd_nz = 1'b1; ex(GP, 5, 0, 0); end
      26: begin thr; tc.save_idx = 32'h1; ex(GP, 5, 0, 0); end
      27: begin thr; tc.debug_opt_in = 1'b1; ex(GP, 5, 0, 0); end
      28: begin thr; fl[3] = 1'b0; tc.gs_limit = 32'h0000_1ffe; ex(GP, 5, 0, 0); end
      29: begin thr; fl[3] = 1'b0; end
      30: begin lf = 32'h6; ex(OK, 0, 0, 0); end
      31: ex(OK, 0, 0, 0);
      32: begin sf[15:8] = epa_pkg::PT_SHADOW_R; dmap.pt = epa_pkg::PT_SHADOW_R; end
      33: begin thr; tc.prev_ssp = 64'h1; ex(GP, 5, 0, 0); end
      34: begin
        sf[15:8] = epa_pkg::PT_SHADOW_F;
        sf[epa_pkg::SI_RESTRICT] = 1'b1;
        ex(GP, 2, 0, 0);
      end
      default: ;
    endcase
    // each input is driven once per case, so no twist fights a default
    leaf_idx <= lf;
    {in_enclave, si_in_prot, dst_in_prot, track_done, wide_mode} <= fl[7:3];
    {dst_in_use, base_conflict, excl_conflict} <= fl[2:0];
    rbx <= rb;
    rcx <= rc;
    si_map <= smap;
    dst_map <= dmap;
    thr_fields <= tc;
    si_data <= {hb, 383'h0, 64'h0, sf};
  endtask

  // one instruction: pulse start, wait bounded for completion, check the record
  task automatic run_op;
    int n;
    logic hit;
    logic [31:0] d;
    @(posedge clk);
    start <= 1'b1;
    n = 0;
    hit = 1'b0;
    // the first pass already looks behind the edge that takes start
    while (!hit && n < 8) begin
      @(posedge clk);
      start <= 1'b0;
      #1;
      n++;
      hit = (res.done === 1'b1);
    end
    if (lat == 0) begin
      `CHK(hit, 1'b0)
    end else begin
      `CHK(n, lat)
      `CHK(res.outcome, eo)
      `CHK(res.addr, ea)
      `CHK(lock_hold, 1'b0)
      `CHK(res.map_wr, eo == OK)
      `CHK(res.flags_wr, eo == OK || eo == ER)
      if (eo == OK || eo == ER) begin
        `CHK(res.rax, er)
        `CHK(res.zf, eo == ER)
        `CHK(res.arith, 5'h0)
        reg_read(epa_pkg::REG_RAX, d);
        `CHK(d, er[31:0])
        reg_read(epa_pkg::REG_STATUS, d);
        `CHK(d, {28'h0, eo, eo == ER})
      end
    end
  endtask

  // main sequence: reset, register checks, then the case table
  initial begin
    logic [31:0] d;
    {reset_n, reg_wr, reg_rd, start, in_enclave, si_in_prot, dst_in_prot} = '0;
    {dst_in_use, base_conflict, excl_conflict, track_done, wide_mode} = '0;
    {reg_addr, reg_wdata, leaf_idx, rbx, rcx, si_data, active_owner} = '0;
    si_map = '0;
    dst_map = '0;
    thr_fields = '0;
    clk_en = 1'b1;
    elr_base = ELB;
    elr_end = ELE;
    seed = 32'hd04d;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    `CHK(res.outcome, 3'h0)
    `CHK(res.rax, 64'h0)
    `CHK({res.done, res.zf, res.map_wr, res.flags_wr, lock_hold, lock_req}, 6'h0)
    reg_read(epa_pkg::REG_CTRL, d);
    `CHK(d, epa_pkg::CTRL_RST)
    reg_read(4'hc, d);
    `CHK(d, 32'h0)
    reg_write(epa_pkg::REG_STATUS, 32'hffff_ffff);
    reg_read(epa_pkg::REG_STATUS, d);
    `CHK(d, 32'h0)
    for (int k = 0; k < 35; k++) begin
      if (k == 31) reg_write(epa_pkg::REG_CTRL, 32'h0);
      if (k == 32) begin
        // mid-run reset must bring back the enabled control word and a clear record
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        `CHK(res.outcome, 3'h0)
        reg_read(epa_pkg::REG_CTRL, d);
        `CHK(d, epa_pkg::CTRL_RST)
        reg_write(epa_pkg::REG_CTRL, 32'h3);
      end
      @(posedge clk);
      set_case(k);
      run_op;
    end
    conclude;
  end

  // watchdog: the table needs about 250 cycles, allow twenty thousand
  initial begin
    #400_000;
    bad_count++;
    conclude;
  end
endmodule
`default_nettype wire
